// ### dv/imc_host.sv
`timescale 1ns/1ps

module imc_host (
	// clock
	input wire logic mclk,
	// register port
	output imc_pkg::imc_req_t req,
	input wire logic [7:0] reg_rdata
);
	initial begin
		req = '0;
	end

	// ===========================================
	// single-byte accesses
	// a mode change is one write, with no follow-up access
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		// released lines flip so stale values never look live
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		@(posedge mclk);
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : imc_host

// ### dv/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	logic mclk;
	logic rst;
	imc_pkg::imc_req_t req;
	logic [7:0] reg_rdata;
	logic sample_tick;
	logic [2:0][15:0] accel_raw;
	logic [2:0][15:0] gyro_raw;
	logic [15:0] temp_raw;
	logic [2:0][15:0] accel_out;
	logic [2:0][15:0] gyro_out;
	logic [15:0] temp_out;
	logic data_valid;
	imc_pkg::imc_gpow_t gyro_pow;
	logic accel_on;
	logic joint_mode;
	logic [2:0] output_rate;
	int n_fail = 0;
	int compares = 0;
	logic [7:0] rb;

	imc_power_mode imc_power_mode_inst (.mclk(mclk), .rst(rst), .req(req),
		.reg_rdata(reg_rdata), .sample_tick(sample_tick),
		.accel_raw(accel_raw), .gyro_raw(gyro_raw), .temp_raw(temp_raw),
		.accel_out(accel_out), .gyro_out(gyro_out), .temp_out(temp_out),
		.data_valid(data_valid), .gyro_pow(gyro_pow), .accel_on(accel_on),
		.joint_mode(joint_mode), .output_rate(output_rate));
	imc_host imc_host_inst (.mclk(mclk), .req(req), .reg_rdata(reg_rdata));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ===========================================
	// helpers
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one sample strobe; outputs are looked at once they have settled
	task automatic tick();
		@(posedge mclk);
		sample_tick <= 1'b1;
		@(posedge mclk);
		sample_tick <= 1'b0;
		#1;
	endtask : tick

	task automatic close_out();
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	// ===========================================
	// scenarios
	task automatic sc_reset();
		chk("gyro_pow", 16'h0000, 16'(gyro_pow));
		chk("accel_on", 16'h0000, 16'(accel_on));
		imc_host_inst.rd(8'h10, rb);
		chk("rate reg", 16'h0000, 16'(rb));
		imc_host_inst.wr(8'h44, 8'h5a);
		imc_host_inst.rd(8'h44, rb);
		chk("unmapped", 16'h0000, 16'(rb));
	endtask : sc_reset

	task automatic sc_accel();
		imc_host_inst.wr(8'h20, 8'h60);
		tick();
		chk("accel_on", 16'h0001, 16'(accel_on));
		chk("joint", 16'h0000, 16'(joint_mode));
		chk("gyro_pow", 16'h0000, 16'(gyro_pow));
		chk("rate", 16'h0003, 16'(output_rate));
		tick();
		chk("valid", 16'h0001, 16'(data_valid));
		chk("accel", 16'h0001, accel_out[0]);
		chk("gyro off", 16'h0000, gyro_out[1]);
		chk("temp", 16'h0005, temp_out);
	endtask : sc_accel

	// every rate code at widest scale with low power requested
	task automatic sc_rates();
		logic [1:0] e;
		logic [1:0] prev;
		prev = 2'b00;
		imc_host_inst.wr(8'h12, 8'h80);
		for (int c = 0; c < 8; c++) begin
			e = (c == 0 || c == 7) ? 2'b00 : (c < 4 ? 2'b01 : 2'b10);
			imc_host_inst.wr(8'h10, {3'(c), 5'b11000});
			#1;
			chk("held", 16'(prev), 16'(gyro_pow));
			tick();
			chk("gyro_pow", 16'(e), 16'(gyro_pow));
			chk("joint", 16'h0001, 16'(joint_mode));
			chk("rate", (c == 7) ? 16'h0 : 16'(c), 16'(output_rate));
			prev = e;
		end
		imc_host_inst.rd(8'h10, rb);
		chk("rate reg", 16'h00f8, 16'(rb));
	endtask : sc_rates

	task automatic sc_normal();
		imc_host_inst.wr(8'h10, 8'h38);
		imc_host_inst.wr(8'h12, 8'h00);
		tick();
		chk("lp clear", 16'h0002, 16'(gyro_pow));
		imc_host_inst.wr(8'h12, 8'h80);
		imc_host_inst.wr(8'h10, 8'h30);
		tick();
		chk("narrow fs", 16'h0002, 16'(gyro_pow));
		tick();
		chk("gyro sign", 16'hfff0, gyro_out[2]);
		chk("accel", 16'h0001, accel_out[1]);
	endtask : sc_normal

	// zero-level inputs, a counterclockwise unit, then back to accel-only
	task automatic sc_zero();
		@(posedge mclk);
		accel_raw <= {3{16'h8000}};
		gyro_raw <= {3{16'hffff}};
		temp_raw <= 16'h0000;
		tick();
		chk("accel zero", 16'h0000, accel_out[0]);
		chk("gyro ccw", 16'h0001, gyro_out[0]);
		chk("temp zero", 16'h0000, temp_out);
		imc_host_inst.wr(8'h20, 8'h40);
		tick();
		chk("joint", 16'h0000, 16'(joint_mode));
		chk("gyro_pow", 16'h0000, 16'(gyro_pow));
		chk("rate", 16'h0002, 16'(output_rate));
		tick();
		chk("gyro off", 16'h0000, gyro_out[0]);
	endtask : sc_zero

	initial begin
		rst = 1'b1;
		sample_tick = 1'b0;
		accel_raw = {3{16'h8001}};
		gyro_raw = {3{16'h0010}};
		temp_raw = 16'h0005;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		sc_reset();
		sc_accel();
		sc_rates();
		sc_normal();
		sc_zero();
		close_out();
	end

	// guard against a hung run
	initial begin
		#100000;
		n_fail++;
		close_out();
	end
endmodule : tb_top

// ### hdl/imc_consts.svh
`ifndef IMC_CONSTS_SVH
`define IMC_CONSTS_SVH

// ===========================================
// register offsets
`define IMC_OFS_GYRO_RATE 8'h10
`define IMC_OFS_GYRO_MODE 8'h12
`define IMC_OFS_ACCEL_RATE 8'h20

// ===========================================
// field positions
`define IMC_RATE_MSB 7
`define IMC_RATE_LSB 5
`define IMC_FS_MSB 4
`define IMC_FS_LSB 3
`define IMC_LP_BIT 7

// ===========================================
// reset values and codes
`define IMC_REG_RST 8'h00
`define IMC_RATE_OFF 3'h0
`define IMC_RATE_LP_MAX 3'h3
`define IMC_RATE_RSVD 3'h7
`define IMC_FS_WIDEST 2'h3
`define IMC_ACC_MID 16'h8000
`define IMC_TEMP_REF 16'h0000

`endif

// ### hdl/imc_pkg.sv
package imc_pkg;

	// ===========================================
	// gyroscope power states
	typedef enum logic [1:0] {
		IMC_GP_DOWN = 2'b00,
		IMC_GP_LOW = 2'b01,
		IMC_GP_NORMAL = 2'b10
	} imc_gpow_t;

	// ===========================================
	// operating modes
	typedef enum logic [1:0] {
		IMC_M_IDLE = 2'b00,
		IMC_M_ACCEL = 2'b01,
		IMC_M_JOINT = 2'b10
	} imc_mode_t;

	// ===========================================
	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} imc_req_t;

	// ===========================================
	// applied configuration
	typedef struct packed {
		imc_mode_t mode;
		logic [2:0] rate;
		logic [2:0] acc_rate;
		logic lp;
		logic [1:0] fs;
	} imc_cfg_t;

endpackage : imc_pkg

// ### hdl/imc_power_mode.sv
// What this block does
// - accel write: accel normal, gyro powered down
// - gyro rate write: both active unless rate code 000 or 111 (gyro down), one rate
// - mode change takes one register write
// - gyro has down, low-power, normal only
// - rate code 000 down, 001..110 rates
// - low power only at three lowest rates
// - low power needs bit set, else normal
// - low power only at widest full scale
// - accel output two's complement, zero is 0
// - counterclockwise rotation reads positive
// - temperature reads zero at reference point
`timescale 1ns/1ps
`include "imc_consts.svh"

module imc_power_mode #(
	parameter int AXES = 3,
	parameter logic [15:0] TEMP_REF = `IMC_TEMP_REF
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire imc_pkg::imc_req_t req,
	output logic [7:0] reg_rdata,
	// sensing core
	input wire logic sample_tick,
	input wire logic [AXES-1:0][15:0] accel_raw,
	input wire logic [AXES-1:0][15:0] gyro_raw,
	input wire logic [15:0] temp_raw,
	// data outputs
	output logic [AXES-1:0][15:0] accel_out,
	output logic [AXES-1:0][15:0] gyro_out,
	output logic [15:0] temp_out,
	output logic data_valid,
	// power state
	output imc_pkg::imc_gpow_t gyro_pow,
	output logic accel_on,
	output logic joint_mode,
	output logic [2:0] output_rate
);

	// ===========================================
	// decode
	function automatic imc_pkg::imc_gpow_t gyro_power(
		input logic [2:0] rate,
		input logic lp,
		input logic [1:0] fs
	);
		if (rate == `IMC_RATE_OFF || rate == `IMC_RATE_RSVD) begin
			gyro_power = imc_pkg::IMC_GP_DOWN;
		end else if (lp && rate <= `IMC_RATE_LP_MAX &&
			fs == `IMC_FS_WIDEST) begin
			gyro_power = imc_pkg::IMC_GP_LOW;
		end else begin
			gyro_power = imc_pkg::IMC_GP_NORMAL;
		end
	endfunction : gyro_power

	// ===========================================
	// register file
	logic [7:0] gyro_rate_control;
	logic [7:0] gyro_mode_control;
	logic [7:0] accel_rate_control;
	imc_pkg::imc_mode_t pend_mode;
	imc_pkg::imc_cfg_t cfg;
	imc_pkg::imc_cfg_t next_cfg;
	logic [7:0] next_rdata;
	wire logic wr_rate = req.wr && req.addr == `IMC_OFS_GYRO_RATE;
	wire logic wr_gmode = req.wr && req.addr == `IMC_OFS_GYRO_MODE;
	wire logic wr_acc = req.wr && req.addr == `IMC_OFS_ACCEL_RATE;

	// unmapped offsets read as zero
	assign next_rdata =
		(req.addr == `IMC_OFS_GYRO_RATE) ? gyro_rate_control :
		(req.addr == `IMC_OFS_GYRO_MODE) ? gyro_mode_control :
		(req.addr == `IMC_OFS_ACCEL_RATE) ? accel_rate_control :
		`IMC_REG_RST;

	always_ff @(posedge mclk) begin
		if (rst) begin
			gyro_rate_control <= `IMC_REG_RST;
			gyro_mode_control <= `IMC_REG_RST;
			accel_rate_control <= `IMC_REG_RST;
			pend_mode <= imc_pkg::IMC_M_IDLE;
			reg_rdata <= `IMC_REG_RST;
		end else begin
			if (wr_rate) begin
				gyro_rate_control <= req.wdata;
				pend_mode <= imc_pkg::IMC_M_JOINT;
			end
			if (wr_gmode) begin
				gyro_mode_control <= req.wdata;
			end
			if (wr_acc) begin
				accel_rate_control <= req.wdata;
				pend_mode <= imc_pkg::IMC_M_ACCEL;
			end
			if (req.rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// ===========================================
	// applied configuration
	// staged until the sample edge so that no sample mixes two settings
	assign next_cfg = '{
		mode: pend_mode,
		rate: gyro_rate_control[`IMC_RATE_MSB:`IMC_RATE_LSB],
		acc_rate: accel_rate_control[`IMC_RATE_MSB:`IMC_RATE_LSB],
		lp: gyro_mode_control[`IMC_LP_BIT],
		fs: gyro_rate_control[`IMC_FS_MSB:`IMC_FS_LSB]
	};

	wire logic next_joint = next_cfg.mode == imc_pkg::IMC_M_JOINT;
	wire imc_pkg::imc_gpow_t next_gpow = next_joint ?
		gyro_power(next_cfg.rate, next_cfg.lp, next_cfg.fs) :
		imc_pkg::IMC_GP_DOWN;
	// reserved code reports as no rate
	wire logic [2:0] next_grate = (next_cfg.rate == `IMC_RATE_RSVD) ?
		`IMC_RATE_OFF : next_cfg.rate;
	wire logic [2:0] next_orate = next_joint ? next_grate :
		next_cfg.acc_rate;

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg <= '0;
			gyro_pow <= imc_pkg::IMC_GP_DOWN;
			accel_on <= 1'b0;
			joint_mode <= 1'b0;
			output_rate <= `IMC_RATE_OFF;
		end else if (sample_tick) begin
			cfg <= next_cfg;
			gyro_pow <= next_gpow;
			accel_on <= next_cfg.mode != imc_pkg::IMC_M_IDLE;
			joint_mode <= next_joint;
			output_rate <= next_orate;
		end
	end

	// ===========================================
	// output data formatting
	wire logic gyro_live = gyro_pow != imc_pkg::IMC_GP_DOWN;

	always_ff @(posedge mclk) begin
		if (rst) begin
			temp_out <= 16'h0000;
			data_valid <= 1'b0;
		end else begin
			data_valid <= sample_tick && accel_on;
			if (sample_tick && accel_on) begin
				temp_out <= temp_raw - TEMP_REF;
			end
		end
	end

	genvar ax;
	generate
		for (ax = 0; ax < AXES; ax++) begin : g_axis
			always_ff @(posedge mclk) begin
				if (rst) begin
					accel_out[ax] <= 16'h0000;
					gyro_out[ax] <= 16'h0000;
				end else if (sample_tick && accel_on) begin
					// mid-scale raw code maps to all-zero
					accel_out[ax] <= accel_raw[ax] ^ `IMC_ACC_MID;
					// raw core is clockwise-positive, so negate
					gyro_out[ax] <= gyro_live ?
						16'h0000 - gyro_raw[ax] : 16'h0000;
				end
			end
		end
	endgenerate

	// ===========================================
	// checks
	sequence s_tick_joint;
		sample_tick && pend_mode == imc_pkg::IMC_M_JOINT;
	endsequence

	sequence s_tick_accel;
		sample_tick && pend_mode == imc_pkg::IMC_M_ACCEL;
	endsequence

	sequence s_tick_data;
		sample_tick && accel_on;
	endsequence

	property p_accel_only;
		@(posedge mclk) disable iff (rst)
		s_tick_accel |=> accel_on && !joint_mode &&
			gyro_pow == imc_pkg::IMC_GP_DOWN;
	endproperty
	a_accel_only: assert property (p_accel_only)
		else $error("accel-only mode left gyro powered");

	property p_joint;
		@(posedge mclk) disable iff (rst)
		s_tick_joint |=> accel_on && joint_mode &&
			output_rate == $past(next_grate);
	endproperty
	a_joint: assert property (p_joint)
		else $error("joint mode not applied at common rate");

	property p_one_write;
		@(posedge mclk) disable iff (rst)
		wr_rate && !wr_acc ##1 (!req.wr)[*2] |->
			pend_mode == imc_pkg::IMC_M_JOINT;
	endproperty
	a_one_write: assert property (p_one_write)
		else $error("single write did not select joint mode");

	property p_three_states;
		@(posedge mclk) disable iff (rst)
		gyro_pow != 2'b11;
	endproperty
	a_three_states: assert property (p_three_states)
		else $error("gyro power state outside three states");

	property p_rate_off;
		@(posedge mclk) disable iff (rst)
		s_tick_joint and next_cfg.rate == `IMC_RATE_OFF |=>
			gyro_pow == imc_pkg::IMC_GP_DOWN && output_rate == 3'h0;
	endproperty
	a_rate_off: assert property (p_rate_off)
		else $error("rate code zero did not power down gyro");

	property p_low_rates;
		@(posedge mclk) disable iff (rst)
		gyro_pow == imc_pkg::IMC_GP_LOW |->
			output_rate != 3'h0 && output_rate <= 3'h3 && cfg.lp;
	endproperty
	a_low_rates: assert property (p_low_rates)
		else $error("low power at a rate above the lowest three");

	property p_lp_clear;
		@(posedge mclk) disable iff (rst)
		s_tick_joint and !next_cfg.lp and next_cfg.rate != 3'h0 and
			next_cfg.rate != 3'h7 |=> gyro_pow == imc_pkg::IMC_GP_NORMAL;
	endproperty
	a_lp_clear: assert property (p_lp_clear)
		else $error("gyro not normal with low-power bit clear");

	property p_widest_fs;
		@(posedge mclk) disable iff (rst)
		gyro_pow == imc_pkg::IMC_GP_LOW |-> cfg.fs == 2'h3;
	endproperty
	a_widest_fs: assert property (p_widest_fs)
		else $error("low power outside widest full scale");

	property p_accel_zero;
		@(posedge mclk) disable iff (rst)
		s_tick_data and accel_raw[0] == 16'h8000 |=>
			data_valid && accel_out[0] == 16'h0000;
	endproperty
	a_accel_zero: assert property (p_accel_zero)
		else $error("zero acceleration not all-zero code");

	property p_ccw_positive;
		@(posedge mclk) disable iff (rst)
		s_tick_data and gyro_live and gyro_raw[0] == 16'hffff |=>
			gyro_out[0] == 16'h0001;
	endproperty
	a_ccw_positive: assert property (p_ccw_positive)
		else $error("counterclockwise rate not positive");

	property p_temp_zero;
		@(posedge mclk) disable iff (rst)
		s_tick_data and temp_raw == TEMP_REF |=> temp_out == 16'h0000;
	endproperty
	a_temp_zero: assert property (p_temp_zero)
		else $error("temperature not zero at reference");

	property p_reserved;
		@(posedge mclk) disable iff (rst)
		s_tick_joint and next_cfg.rate == 3'h7 |=>
			gyro_pow == imc_pkg::IMC_GP_DOWN;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved rate code did not power down");

	property p_gyro_with_accel;
		@(posedge mclk) disable iff (rst)
		gyro_pow != imc_pkg::IMC_GP_DOWN |-> accel_on && joint_mode;
	endproperty
	a_gyro_with_accel: assert property (p_gyro_with_accel)
		else $error("gyro powered outside joint mode");

	property p_high_normal;
		@(posedge mclk) disable iff (rst)
		s_tick_joint and next_cfg.rate > `IMC_RATE_LP_MAX and
			next_cfg.rate != `IMC_RATE_RSVD |=>
			gyro_pow == imc_pkg::IMC_GP_NORMAL;
	endproperty
	a_high_normal: assert property (p_high_normal)
		else $error("gyro not normal at a high rate");

	property p_gyro_gate;
		@(posedge mclk) disable iff (rst)
		s_tick_data and !gyro_live |=> gyro_out[0] == 16'h0000;
	endproperty
	a_gyro_gate: assert property (p_gyro_gate)
		else $error("gyro data shown while powered down");

	property p_hold_between;
		@(posedge mclk) disable iff (rst)
		!sample_tick |=> $stable(gyro_pow) && $stable(output_rate);
	endproperty
	a_hold_between: assert property (p_hold_between)
		else $error("power state changed between samples");

endmodule : imc_power_mode
